// [core/lpd_pkg.sv]
// Package: constants, types and register map of the panel/alignment block
package lpd_pkg;

  // Clock rate and derived timing
  localparam int unsigned CLK_HZ          = 40000000;
  localparam int unsigned SHORT_PRESS_MS  = 1000;
  localparam int unsigned ALIGN_PRESS_MS  = 2000;
  localparam int unsigned RESET_PRESS_MS  = 5000;
  localparam int unsigned BURST_PERIOD_MS = 5000;
  localparam int unsigned ALIGN_TIME_MS   = 1000;
  localparam int unsigned ACT_FLASH_MS    = 50;
  // Full periods of the heartbeat in milliseconds
  localparam int unsigned HB_NORMAL_MS    = 1000; // 1 Hz
  localparam int unsigned HB_SYNC_MS      = 2000; // 0.5 Hz
  localparam int unsigned HB_ALIGN_MS     = 200;  // 5 Hz
  localparam int unsigned BLINK_MS        = 200;  // one error blink phase
  localparam int unsigned MS_CYCLES       = CLK_HZ / 1000;

  // Channels
  localparam int unsigned NUM_CH = 4;

  // Register byte offsets
  localparam logic [7:0] REG_CTRL   = 8'h00;
  localparam logic [7:0] REG_CFG    = 8'h04;
  localparam logic [7:0] REG_PARAM  = 8'h08;
  localparam logic [7:0] REG_STATUS = 8'h0C;
  localparam logic [7:0] REG_LEDS   = 8'h10;
  localparam logic [7:0] REG_ID     = 8'h14;

  // CTRL bits (write one = pulse)
  localparam int unsigned CTRL_RESET_REQ = 0;
  localparam int unsigned CTRL_ALIGN_ALL = 1;
  // CFG fields
  localparam int unsigned CFG_SYNC_BIT   = 0;
  localparam int unsigned CFG_ACT_LSB    = 4;
  localparam int unsigned CFG_BLANK_LSB  = 8;
  localparam logic [31:0] CFG_RESET      = 32'h000000F0;
  // PARAM write: channel select and changed mask
  localparam int unsigned PARAM_CH_LSB   = 0;

  // Error codes as blink counts
  localparam logic [3:0] ERR_NONE    = 4'h0;
  localparam logic [3:0] ERR_SHORT   = 4'h1;
  localparam logic [3:0] ERR_OPEN    = 4'h2;
  localparam logic [3:0] ERR_FREQ    = 4'h3;
  localparam logic [3:0] ERR_DISTURB = 4'h4;
  localparam logic [3:0] ERR_TIMEOUT = 4'h7;
  localparam logic [3:0] ERR_LOOP    = 4'h8;

  // Identification value, arbitrary
  localparam logic [31:0] ID_VALUE = 32'h00A5C001;

  // AXI responses
  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // Button decode classes
  typedef enum logic [1:0] {PRESS_NONE, PRESS_SHORT, PRESS_ALIGN,
                            PRESS_RESET} lpd_press_t;

  // Front panel lamps
  typedef struct packed {
    logic [3:0] channel;
    logic       error;
    logic       rx_act;
    logic       tx_act;
    logic       heartbeat;
  } lpd_leds_t;

endpackage

// [core/lpd_panel.sv]
// Front panel indicators, pushbutton decode and channel alignment sequencing
`timescale 1ns/100ps
module lpd_panel
  import lpd_pkg::*;
#(
  parameter int unsigned MS_DIV     = MS_CYCLES,
  parameter int unsigned ALIGN_MS   = ALIGN_TIME_MS,
  parameter int unsigned BAUD_RATE  = 4800
) (
  // Clock and reset
  input  wire logic                core_clk_i,
  input  wire logic                rst_i,
  input  wire logic                wdog_rst_i,
  // AXI4-Lite slave
  input  wire logic [7:0]          s_axi_awaddr,
  input  wire logic                s_axi_awvalid,
  output logic                     s_axi_awready,
  input  wire logic [31:0]         s_axi_wdata,
  input  wire logic [3:0]          s_axi_wstrb,
  input  wire logic                s_axi_wvalid,
  output logic                     s_axi_wready,
  output logic [1:0]               s_axi_bresp,
  output logic                     s_axi_bvalid,
  input  wire logic                s_axi_bready,
  input  wire logic [7:0]          s_axi_araddr,
  input  wire logic                s_axi_arvalid,
  output logic                     s_axi_arready,
  output logic [31:0]              s_axi_rdata,
  output logic [1:0]               s_axi_rresp,
  output logic                     s_axi_rvalid,
  input  wire logic                s_axi_rready,
  // Pins and channel logic
  input  wire logic                front_pushbutton_i,
  input  wire logic                rs485_rx_i,
  input  wire logic                rs485_tx_i,
  input  wire logic [NUM_CH-1:0]   loop_detect_i,
  input  wire logic [NUM_CH*4-1:0] loop_error_i,
  input  wire logic [NUM_CH-1:0]   loop_settled_i,
  // Outputs
  output lpd_leds_t                leds_o,
  output logic [NUM_CH-1:0]        vehicle_detect_o,
  output logic [NUM_CH-1:0]        align_load_o,
  output logic                     detector_reset_o,
  output logic [15:0]              service_baud_o
);

  initial begin
    if (MS_DIV < 2 || MS_DIV > 65536 || ALIGN_MS < 1 || ALIGN_MS > 8191 ||
        BAUD_RATE == 0 || BAUD_RATE > 65535)
      $error("lpd_panel: unsupported parameter");
  end

  ////////////////////////////////////////////////////////////////////////////
  // Input synchronisers
  logic [2:0] sync1_q;
  logic [2:0] sync2_q;
  logic [2:0] sync3_q;
  always_ff @(posedge core_clk_i) begin
    if (rst_i) begin
      sync1_q <= 3'h0;
      sync2_q <= 3'h0;
      sync3_q <= 3'h0;
    end else begin
      sync1_q <= {rs485_tx_i, rs485_rx_i, front_pushbutton_i};
      sync2_q <= sync1_q;
      sync3_q <= sync2_q;
    end
  end
  logic btn;
  assign btn = sync2_q[0];

  ////////////////////////////////////////////////////////////////////////////
  // Millisecond tick
  logic [15:0] pre_q;
  logic        ms_tick;
  assign ms_tick = (pre_q == 16'(MS_DIV - 1));
  always_ff @(posedge core_clk_i) begin
    if (rst_i || ms_tick) pre_q <= 16'h0000;
    else                  pre_q <= pre_q + 16'h0001;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Registers
  logic [31:0]       cfg_q;
  logic              reset_req;   // pulse
  logic              align_req;   // pulse
  logic              param_req;   // pulse
  logic [NUM_CH-1:0] param_mask;
  logic              sync_en;
  logic [NUM_CH-1:0] ch_active;
  logic [7:0]        blank_timeout;
  assign sync_en       = cfg_q[CFG_SYNC_BIT];
  assign ch_active     = cfg_q[CFG_ACT_LSB +: NUM_CH];
  assign blank_timeout = cfg_q[CFG_BLANK_LSB +: 8];

  // Write channel: both halves latched, answered when both present
  logic        aw_q, w_q;
  logic [7:0]  awaddr_q;
  logic [31:0] wdata_q;
  logic [3:0]  wstrb_q;
  logic        wr_go;
  assign wr_go = aw_q && w_q && !s_axi_bvalid;
  assign s_axi_awready = !aw_q;
  assign s_axi_wready  = !w_q;

  always_ff @(posedge core_clk_i) begin
    if (rst_i) begin
      aw_q     <= 1'b0;
      w_q      <= 1'b0;
      awaddr_q <= 8'h00;
      wdata_q  <= 32'h0;
      wstrb_q  <= 4'h0;
    end else begin
      if (s_axi_awvalid && !aw_q) begin
        aw_q     <= 1'b1;
        awaddr_q <= s_axi_awaddr;
      end else if (wr_go) aw_q <= 1'b0;
      if (s_axi_wvalid && !w_q) begin
        w_q     <= 1'b1;
        wdata_q <= s_axi_wdata;
        wstrb_q <= s_axi_wstrb;
      end else if (wr_go) w_q <= 1'b0;
    end
  end

  always_ff @(posedge core_clk_i) begin
    if (rst_i) begin
      cfg_q        <= CFG_RESET;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= RESP_OKAY;
      reset_req    <= 1'b0;
      align_req    <= 1'b0;
      param_req    <= 1'b0;
      param_mask   <= '0;
    end else begin
      reset_req <= 1'b0;
      align_req <= 1'b0;
      param_req <= 1'b0;
      if (s_axi_bvalid && s_axi_bready) s_axi_bvalid <= 1'b0;
      if (wr_go) begin
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= RESP_OKAY;
        if (awaddr_q == REG_CTRL) begin
          if (wstrb_q[0]) begin
            reset_req <= wdata_q[CTRL_RESET_REQ];
            align_req <= wdata_q[CTRL_ALIGN_ALL];
          end
        end else if (awaddr_q == REG_CFG) begin
          for (int b = 0; b < 4; b++)
            if (wstrb_q[b]) cfg_q[b*8 +: 8] <= wdata_q[b*8 +: 8];
        end else if (awaddr_q == REG_PARAM) begin
          // Second channel of a pair takes no direct writes
          if (wstrb_q[0]) begin
            param_req  <= 1'b1;
            param_mask <= wdata_q[PARAM_CH_LSB +: NUM_CH]
                          & 4'b0101;
          end
        end else if (awaddr_q == REG_STATUS || awaddr_q == REG_LEDS ||
                     awaddr_q == REG_ID) begin
          s_axi_bresp <= RESP_SLVERR;  // Read-only
        end else begin
          s_axi_bresp <= RESP_SLVERR;
        end
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Pushbutton press length decode
  logic [12:0] press_ms_q;
  lpd_press_t  press;
  logic        btn_rel;
  assign btn_rel = !btn && sync3_q[0];
  always_ff @(posedge core_clk_i) begin
    if (rst_i || !btn) press_ms_q <= 13'h0;
    else if (ms_tick && press_ms_q != 13'h1FFF) press_ms_q <= press_ms_q + 13'h1;
  end
  always_comb begin
    press = PRESS_NONE;
    if (btn_rel) begin
      if (press_ms_q < 13'(SHORT_PRESS_MS))      press = PRESS_SHORT;
      else if (press_ms_q <= 13'(ALIGN_PRESS_MS)) press = PRESS_ALIGN;
      else if (press_ms_q > 13'(RESET_PRESS_MS))  press = PRESS_RESET;
      else                                         press = PRESS_NONE;
    end
  end

  // Blanking toggle, disabled by a zero timeout
  logic blank_q;
  always_ff @(posedge core_clk_i) begin
    if (rst_i) blank_q <= 1'b0;
    else if (press == PRESS_SHORT && blank_timeout != 8'h00)
      blank_q <= !blank_q;
  end

  // Detector reset pulse; all sources converge here
  logic any_reset;
  assign any_reset = reset_req || wdog_rst_i || press == PRESS_RESET;
  always_ff @(posedge core_clk_i) begin
    if (rst_i) detector_reset_o <= 1'b1;
    else       detector_reset_o <= any_reset;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Alignment sequencing per channel
  logic              full_align;
  logic [NUM_CH-1:0] align_start;
  assign full_align = detector_reset_o || align_req ||
                      press == PRESS_ALIGN;
  // Pair partner follows the first channel's parameters
  assign align_start = full_align ? ch_active :
                       (param_req ? ((param_mask | (param_mask << 1))
                                     & ch_active) : '0);

  logic [NUM_CH-1:0] aligning_q;
  logic [NUM_CH-1:0] detect_q;
  logic [3:0]        err_q [NUM_CH];
  logic [NUM_CH-1:0] ch_err;
  logic [NUM_CH-1:0] ch_lamp;
  logic [12:0]       burst_ms_q;
  logic              blink_on;
  logic [3:0]        blink_idx;
  always_ff @(posedge core_clk_i) begin
    if (rst_i || ms_tick && burst_ms_q == 13'(BURST_PERIOD_MS - 1))
      burst_ms_q <= 13'h0;
    else if (ms_tick) burst_ms_q <= burst_ms_q + 13'h1;
  end
  assign blink_idx = 4'(burst_ms_q / 13'(2 * BLINK_MS));
  assign blink_on  = (burst_ms_q % 13'(2 * BLINK_MS)) < 13'(BLINK_MS);

  genvar g;
  generate
    for (g = 0; g < NUM_CH; g++) begin : g_ch
      logic [12:0] amin_q;
      logic        done;
      // Minimum alignment time, then wait for the channel to settle
      assign done = aligning_q[g] && amin_q >= 13'(ALIGN_MS - 1) &&
                    loop_settled_i[g];
      always_ff @(posedge core_clk_i) begin
        if (rst_i) begin
          aligning_q[g] <= 1'b0;
          amin_q        <= 13'h0;
          err_q[g]      <= ERR_NONE;
        end else if (align_start[g]) begin
          aligning_q[g] <= 1'b1;
          amin_q        <= 13'h0;
        end else if (aligning_q[g]) begin
          if (ms_tick && amin_q != 13'h1FFF) amin_q <= amin_q + 13'h1;
          if (done) aligning_q[g] <= 1'b0;
          err_q[g] <= loop_error_i[g*4 +: 4];
        end else begin
          err_q[g] <= loop_error_i[g*4 +: 4];
        end
      end
      // Settings loaded from stored parameters on start
      always_ff @(posedge core_clk_i) begin
        if (rst_i) align_load_o[g] <= 1'b0;
        else       align_load_o[g] <= align_start[g];
      end
      // Detection masked during and until re-armed after alignment
      always_ff @(posedge core_clk_i) begin
        if (rst_i || aligning_q[g] || align_start[g])
          detect_q[g] <= 1'b0;
        else if (!loop_detect_i[g] || detect_q[g] == 1'b0 && !align_load_o[g])
          detect_q[g] <= loop_detect_i[g] && ch_active[g];
      end
      assign ch_err[g]  = err_q[g] != ERR_NONE && ch_active[g];
      assign ch_lamp[g] = aligning_q[g] ? 1'b1 :
                          ch_err[g] ? (blink_idx < err_q[g] && blink_on) :
                          vehicle_detect_o[g];
    end
  endgenerate

  // Held detect: a vehicle present at alignment end stays ignored until gone
  logic [NUM_CH-1:0] armed_q;
  always_ff @(posedge core_clk_i) begin
    if (rst_i) armed_q <= '0;
    else armed_q <= (armed_q | ~loop_detect_i) & ~aligning_q;
  end
  always_ff @(posedge core_clk_i) begin
    if (rst_i) vehicle_detect_o <= '0;
    else vehicle_detect_o <= detect_q & armed_q & ~aligning_q;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Heartbeat generator
  logic [11:0] hb_ms_q;
  logic [11:0] hb_half;
  logic        hb_q;
  always_comb begin
    if (|aligning_q)  hb_half = 12'(HB_ALIGN_MS / 2);
    else if (sync_en) hb_half = 12'(HB_SYNC_MS / 2);
    else              hb_half = 12'(HB_NORMAL_MS / 2);
  end
  always_ff @(posedge core_clk_i) begin
    if (rst_i) begin
      hb_ms_q <= 12'h0;
      hb_q    <= 1'b0;
    end else if (ms_tick) begin
      if (hb_ms_q >= hb_half - 12'h1) begin
        hb_ms_q <= 12'h0;
        hb_q    <= !hb_q;
      end else hb_ms_q <= hb_ms_q + 12'h1;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Activity stretchers for the data bus lamps
  logic [5:0] act_ms_q [2];
  generate
    for (g = 0; g < 2; g++) begin : g_act
      always_ff @(posedge core_clk_i) begin
        if (rst_i) act_ms_q[g] <= 6'h0;
        else if (sync2_q[g+1] != sync3_q[g+1])
          act_ms_q[g] <= 6'(ACT_FLASH_MS);
        else if (ms_tick && act_ms_q[g] != 6'h0)
          act_ms_q[g] <= act_ms_q[g] - 6'h1;
      end
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////////////
  // Lamp outputs, all gated by blanking
  always_ff @(posedge core_clk_i) begin
    if (rst_i) leds_o <= '0;
    else begin
      leds_o.channel   <= blank_q ? '0 : ch_lamp;
      leds_o.error     <= !blank_q && |ch_err;
      leds_o.rx_act    <= !blank_q && act_ms_q[0] != 6'h0;
      leds_o.tx_act    <= !blank_q && act_ms_q[1] != 6'h0;
      leds_o.heartbeat <= !blank_q && hb_q;
    end
  end

  // Service port rate
  always_ff @(posedge core_clk_i) begin
    if (rst_i) service_baud_o <= 16'(BAUD_RATE);
    else       service_baud_o <= 16'(BAUD_RATE);
  end

  ////////////////////////////////////////////////////////////////////////////
  // Read channel: one-cycle answer
  assign s_axi_arready = !s_axi_rvalid;
  always_ff @(posedge core_clk_i) begin
    if (rst_i) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata  <= 32'h0;
      s_axi_rresp  <= RESP_OKAY;
    end else if (s_axi_arvalid && !s_axi_rvalid) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rresp  <= RESP_OKAY;
      if (s_axi_araddr == REG_CFG) s_axi_rdata <= cfg_q;
      else if (s_axi_araddr == REG_STATUS)
        s_axi_rdata <= {20'h0, vehicle_detect_o, aligning_q, blank_q,
                        sync_en, |ch_err, detector_reset_o};
      else if (s_axi_araddr == REG_LEDS)
        s_axi_rdata <= {err_q[3], err_q[2], err_q[1], err_q[0],
                        8'h0, leds_o};
      else if (s_axi_araddr == REG_ID) s_axi_rdata <= ID_VALUE;
      else if (s_axi_araddr == REG_CTRL || s_axi_araddr == REG_PARAM)
        s_axi_rdata <= 32'h0;
      else begin
        s_axi_rdata <= 32'h0;
        s_axi_rresp <= RESP_SLVERR;
      end
    end else if (s_axi_rvalid && s_axi_rready) s_axi_rvalid <= 1'b0;
  end

endmodule

// [verif/lpd_svc_tool.sv]
// Service tool model: register bus master on the far side of the block
`timescale 1ns/100ps
module lpd_svc_tool (
  // Clock
  input  wire logic        core_clk_i,
  // Write channels
  output logic [7:0]       s_axi_awaddr,
  output logic             s_axi_awvalid,
  input  wire logic        s_axi_awready,
  output logic [31:0]      s_axi_wdata,
  output logic [3:0]       s_axi_wstrb,
  output logic             s_axi_wvalid,
  input  wire logic        s_axi_wready,
  input  wire logic [1:0]  s_axi_bresp,
  input  wire logic        s_axi_bvalid,
  output logic             s_axi_bready,
  // Read channels
  output logic [7:0]       s_axi_araddr,
  output logic             s_axi_arvalid,
  input  wire logic        s_axi_arready,
  input  wire logic [31:0] s_axi_rdata,
  input  wire logic [1:0]  s_axi_rresp,
  input  wire logic        s_axi_rvalid,
  output logic             s_axi_rready
);
  // Tool talks at the default service rate
  localparam logic [15:0] TOOL_BAUD = 16'h12C0;
  initial begin
    {s_axi_awaddr, s_axi_awvalid, s_axi_wdata, s_axi_wstrb} = '0;
    {s_axi_wvalid, s_axi_bready, s_axi_araddr} = '0;
    {s_axi_arvalid, s_axi_rready} = '0;
  end
  ////////////////////////////////////////////////////////////////////////////
  // Write: address and data offered together, each held until taken
  task automatic wr(input logic [7:0] a, input logic [31:0] d,
                    output logic [1:0] r);
    logic ad, wd, bd;
    {ad, wd, bd} = 3'h0;
    @(posedge core_clk_i);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_wstrb <= 4'hF;
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= 3'h7;
    while (!bd) begin
      @(negedge core_clk_i);
      ad = ad | (s_axi_awvalid & s_axi_awready);
      wd = wd | (s_axi_wvalid & s_axi_wready);
      bd = s_axi_bvalid;
      r = s_axi_bresp;
      @(posedge core_clk_i);
      // Released lines show garbage, not the old value
      if (ad) {s_axi_awvalid, s_axi_awaddr} <= {1'b0, ~a};
      if (wd) {s_axi_wvalid, s_axi_wdata} <= {1'b0, ~d};
      if (bd) s_axi_bready <= 1'b0;
    end
  endtask
  // Read: address held until taken, data taken with rvalid
  task automatic rd(input logic [7:0] a, output logic [31:0] d,
                    output logic [1:0] r);
    logic ad, dd;
    {ad, dd} = 2'h0;
    @(posedge core_clk_i);
    s_axi_araddr <= a;
    {s_axi_arvalid, s_axi_rready} <= 2'h3;
    while (!dd) begin
      @(negedge core_clk_i);
      ad = ad | (s_axi_arvalid & s_axi_arready);
      dd = s_axi_rvalid;
      {d, r} = {s_axi_rdata, s_axi_rresp};
      @(posedge core_clk_i);
      if (ad) {s_axi_arvalid, s_axi_araddr} <= {1'b0, ~a};
      if (dd) s_axi_rready <= 1'b0;
    end
  endtask
endmodule

// [verif/lpd_panel_sva.sv]
// Concurrent checks on the panel block ports
`timescale 1ns/100ps
module lpd_panel_chk
  import lpd_pkg::*;
(
  // Clock and resets
  input wire logic        core_clk_i,
  input wire logic        rst_i,
  input wire logic        wdog_rst_i,
  // Register bus
  input wire logic        s_axi_awvalid,
  input wire logic        s_axi_awready,
  input wire logic        s_axi_wvalid,
  input wire logic        s_axi_wready,
  input wire logic        s_axi_bvalid,
  input wire logic        s_axi_bready,
  input wire logic        s_axi_arvalid,
  input wire logic        s_axi_arready,
  input wire logic        s_axi_rvalid,
  input wire logic        s_axi_rready,
  // Pins
  input wire logic [15:0] loop_error_i,
  input lpd_leds_t        leds_o,
  input wire logic [3:0]  vehicle_detect_o,
  input wire logic [3:0]  align_load_o,
  input wire logic        detector_reset_o,
  input wire logic [15:0] service_baud_o
);
  default clocking @(posedge core_clk_i); endclocking
  default disable iff (rst_i);
  AST_BAUD: assert property (
    service_baud_o == 16'h12C0) else $error("service baud wrong");
  // Three clear cycles cover the input and lamp registers
  AST_ERR_OFF: assert property (
    (loop_error_i == 16'h0000) [*3] |-> !leds_o.error)
    else $error("error lamp without fault");
  AST_NO_DET_ALIGN: assert property (
    |align_load_o |=> (vehicle_detect_o & $past(align_load_o)) == 4'h0)
    else $error("detection while aligning");
  AST_LOAD_PULSE: assert property (
    |align_load_o |=> (align_load_o & $past(align_load_o)) == 4'h0)
    else $error("settings load not one cycle");
  AST_WDOG: assert property (
    wdog_rst_i |=> detector_reset_o) else $error("watchdog reset lost");
  AST_BRESP_TIME: assert property (
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready
    |-> !s_axi_bvalid ##2 s_axi_bvalid) else $error("write answer late");
  AST_B_DONE: assert property (
    s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid)
    else $error("write answer stuck");
  AST_R_TIME: assert property (
    s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read answer late");
  AST_R_DONE: assert property (
    s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid)
    else $error("read answer stuck");
endmodule
bind lpd_panel lpd_panel_chk u_chk (.core_clk_i, .rst_i, .wdog_rst_i,
  .s_axi_awvalid, .s_axi_awready, .s_axi_wvalid, .s_axi_wready,
  .s_axi_bvalid, .s_axi_bready, .s_axi_arvalid, .s_axi_arready,
  .s_axi_rvalid, .s_axi_rready, .loop_error_i, .leds_o,
  .vehicle_detect_o, .align_load_o, .detector_reset_o, .service_baud_o);

// [verif/tb_top.sv]
// Self-checking bench for the panel and alignment block
`timescale 1ns/100ps
module tb_top;
  import lpd_pkg::*;
  localparam int MS = 2; // Short millisecond keeps the run small
  logic        core_clk_i = 1'b0;
  logic        rst_i = 1'b1;
  logic        wdog_rst_i = 1'b0;
  logic        front_pushbutton_i = 1'b0;
  logic        rs485_rx_i = 1'b0;
  logic        rs485_tx_i = 1'b0;
  logic [3:0]  loop_detect_i = 4'hF;
  logic [15:0] loop_error_i = 16'h0000;
  logic [3:0]  loop_settled_i = 4'hF;
  lpd_leds_t   leds_o;
  logic [3:0]  vehicle_detect_o, align_load_o, s_axi_wstrb;
  logic [3:0]  seen_load = 4'h0;
  logic        detector_reset_o, seen_rst = 1'b0;
  logic [15:0] service_baud_o;
  logic [7:0]  s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata, s_axi_rdata;
  logic [1:0]  s_axi_bresp, s_axi_rresp;
  logic        s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
  logic        s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
  logic        s_axi_rvalid, s_axi_rready;
  int          bad_count = 0;
  int          n_compared = 0;
  always #12.5 core_clk_i = ~core_clk_i;
  lpd_panel #(.MS_DIV(MS), .ALIGN_MS(4)) dut (.core_clk_i, .rst_i,
    .wdog_rst_i, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
    .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
    .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid,
    .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
    .s_axi_rready, .front_pushbutton_i, .rs485_rx_i, .rs485_tx_i,
    .loop_detect_i, .loop_error_i, .loop_settled_i, .leds_o,
    .vehicle_detect_o, .align_load_o, .detector_reset_o, .service_baud_o);
  lpd_svc_tool tool (.core_clk_i, .s_axi_awaddr, .s_axi_awvalid,
    .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid,
    .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
    .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
    .s_axi_rresp, .s_axi_rvalid, .s_axi_rready);
  // Collect load pulses and reset pulses between checks
  always @(negedge core_clk_i) begin
    seen_load <= seen_load | align_load_o;
    seen_rst <= seen_rst | detector_reset_o;
  end
  ////////////////////////////////////////////////////////////////////////////
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp) begin
      bad_count++;
      $display("mismatch at %0t got %h exp %h", $time, got, exp);
    end
  endtask
  // Ends on a falling edge so outputs are settled when looked at
  task automatic cyc(input int n);
    repeat (n) @(posedge core_clk_i);
    @(negedge core_clk_i);
  endtask
  // Skip one lamp change, then time the next full phase
  task automatic half(input int exp);
    int n;
    logic h;
    for (int k = 0; k < 2; k++) begin
      n = 0;
      h = leds_o.heartbeat;
      while (leds_o.heartbeat === h && n < 9000) begin
        cyc(0);
        n++;
      end
    end
    chk((n - exp <= 2 && exp - n <= 2) ? exp : n, exp);
  endtask
  // Hold the button, release, and let the action land
  task automatic press(input int ms);
    @(posedge core_clk_i);
    {seen_load, seen_rst} = 5'h00;
    front_pushbutton_i <= 1'b1;
    repeat (ms * MS) @(posedge core_clk_i);
    front_pushbutton_i <= 1'b0;
    cyc(40);
  endtask
  task automatic t_boot();
    cyc(3);
    chk(leds_o.channel, 4'hF);
    chk(vehicle_detect_o, 4'h0);
    cyc(40);
    chk(leds_o.channel, 4'h0);
    chk(vehicle_detect_o, 4'h0);
    @(posedge core_clk_i);
    loop_detect_i <= 4'h0;
    cyc(4);
    loop_detect_i <= 4'h5;
    cyc(4);
    chk(vehicle_detect_o, 4'h5);
    chk(leds_o.channel, 4'h5);
    $display("test boot done");
  endtask
  task automatic t_regs();
    logic [31:0] d;
    logic [1:0]  r;
    tool.rd(REG_ID, d, r);
    chk(d, ID_VALUE);
    chk(r, RESP_OKAY);
    tool.rd(REG_CFG, d, r);
    chk(d, CFG_RESET);
    tool.wr(REG_ID, 32'h0, r);
    chk(r, RESP_SLVERR);
    tool.rd(8'h1C, d, r);
    chk({r, d}, {RESP_SLVERR, 32'h0});
    chk(service_baud_o, tool.TOOL_BAUD);
    $display("test registers done");
  endtask
  task automatic t_heart();
    logic [1:0] r;
    half(500 * MS);
    tool.wr(REG_CFG, CFG_RESET | 32'h1, r);
    half(1000 * MS);
    tool.wr(REG_CFG, CFG_RESET, r);
    $display("test heartbeat done");
  endtask
  task automatic t_lamps();
    logic [15:0] sets [2] = '{16'h8721, 16'h4343};
    int          c [4];
    logic [3:0]  p;
    for (int s = 0; s < 2; s++) begin
      @(posedge core_clk_i);
      {loop_detect_i, loop_error_i} <= {4'h0, sets[s]};
      cyc(5);
      chk(leds_o.error, 1'b1);
      c = '{0, 0, 0, 0};
      p = leds_o.channel;
      // One whole burst frame holds each burst exactly once
      repeat (5000 * MS) begin
        cyc(0);
        for (int i = 0; i < 4; i++) c[i] += leds_o.channel[i] & !p[i];
        p = leds_o.channel;
      end
      for (int i = 0; i < 4; i++) chk(c[i], sets[s][i*4 +: 4]);
    end
    @(posedge core_clk_i);
    {loop_error_i, rs485_rx_i} <= 17'h1;
    cyc(6);
    chk({leds_o.error, leds_o.rx_act, leds_o.tx_act}, 3'h2);
    repeat (60 * MS) @(posedge core_clk_i);
    rs485_tx_i <= 1'b1;
    cyc(6);
    chk({leds_o.rx_act, leds_o.tx_act}, 2'h1);
    $display("test lamps done");
  endtask
  task automatic t_param();
    logic [1:0] r;
    @(posedge core_clk_i);
    {loop_settled_i, loop_detect_i} <= 8'h3D;
    seen_load = 4'h0;
    tool.wr(REG_PARAM, 32'h2, r);
    cyc(20);
    chk(seen_load, 4'h0);
    tool.wr(REG_PARAM, 32'h4, r);
    cyc(40);
    chk(seen_load, 4'hC);
    chk(leds_o.channel, 4'hD);
    chk(vehicle_detect_o, 4'h1);
    half(100 * MS);
    @(posedge core_clk_i);
    loop_settled_i <= 4'hF;
    cyc(20);
    chk(vehicle_detect_o, 4'h1);
    $display("test parameters done");
  endtask
  task automatic t_ctrl();
    logic [1:0] r;
    {seen_load, seen_rst} = 5'h00;
    tool.wr(REG_CTRL, 32'h1, r);
    cyc(30);
    chk({seen_rst, seen_load}, 5'h1F);
    @(posedge core_clk_i);
    {seen_load, seen_rst} = 5'h00;
    wdog_rst_i <= 1'b1;
    @(posedge core_clk_i);
    wdog_rst_i <= 1'b0;
    cyc(30);
    chk({seen_rst, seen_load}, 5'h1F);
    tool.wr(REG_CFG, 32'h30, r);
    {seen_load, seen_rst} = 5'h00;
    tool.wr(REG_CTRL, 32'h2, r);
    cyc(30);
    chk({seen_rst, seen_load}, 5'h03);
    $display("test control done");
  endtask
  task automatic t_btn();
    logic [1:0] r;
    tool.wr(REG_CFG, CFG_RESET, r);
    @(posedge core_clk_i);
    {loop_detect_i, loop_error_i} <= {4'h0, 12'h000, ERR_SHORT};
    press(400);
    chk(leds_o.error, 1'b1);
    tool.wr(REG_CFG, CFG_RESET | 32'h500, r);
    press(400);
    chk(leds_o, 8'h00);
    press(400);
    chk(leds_o.error, 1'b1);
    press(1500);
    chk({seen_rst, seen_load}, 5'h0F);
    press(3000);
    chk({seen_rst, seen_load}, 5'h00);
    press(5100);
    chk({seen_rst, seen_load}, 5'h1F);
    $display("test button done");
  endtask
  task automatic conclude();
    $display("compared %0d mismatches %0d", n_compared, bad_count);
    if (bad_count == 0 && n_compared > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask
  ////////////////////////////////////////////////////////////////////////////
  // Main sequence
  initial begin
    repeat (20) @(posedge core_clk_i);
    rst_i <= 1'b0;
    t_boot();
    t_regs();
    t_heart();
    t_lamps();
    t_param();
    t_ctrl();
    t_btn();
    conclude();
  end
  // Watchdog: well above the expected run, inside the cycle budget
  initial begin
    repeat (95000) @(posedge core_clk_i);
    bad_count++;
    conclude();
  end
endmodule
